//--- inc/bsm_map.vh
// strap codes, mode codes, pin map codes and timing counts for boot mode select
`ifndef BSM_MAP_VH
`define BSM_MAP_VH

// strap codes as {line2, line1, line0}
`define BSM_STRAP_LOAD        3'h4
`define BSM_STRAP_TWO_WIRE    3'h1
`define BSM_STRAP_FOUR_WIRE   3'h0
`define BSM_STRAP_BREAK_LOAD  3'h2
`define BSM_STRAP_RESTORE     3'h3

// boot flow codes on boot_mode_out
`define BSM_MODE_RUN_FOUR     3'h0
`define BSM_MODE_RUN_TWO      3'h1
`define BSM_MODE_LOAD         3'h2
`define BSM_MODE_BREAK_CHECK  3'h3
`define BSM_MODE_RESTORE      3'h4

// debug port forms
`define BSM_DBG_FOUR_WIRE     1'h0
`define BSM_DBG_TWO_WIRE      1'h1

// reset values
`define BSM_RST_MODE          3'h0
`define BSM_RST_STRAP         3'h0

// break detection: receive line low for one character time at 115200 baud
`define BSM_BREAK_NS          87000
`define BSM_CLK_NS            100
`define BSM_BREAK_CYCLES      (`BSM_BREAK_NS / `BSM_CLK_NS)
// window in which a break is looked for before running
`define BSM_BREAK_WAIT_NS     1000000
`define BSM_BREAK_WAIT_CYCLES (`BSM_BREAK_WAIT_NS / `BSM_CLK_NS)
// typical restore duration, eight seconds
`define BSM_RESTORE_NS        40'd8000000000
`define BSM_RESTORE_CYCLES    (`BSM_RESTORE_NS / `BSM_CLK_NS)

`endif

//--- logic/bsm_break_detect.v
// break detector: reports a receive line held low for a whole break time
`timescale 1ns/1ns
`default_nettype none
module bsm_break_detect
#(
    parameter integer BREAK_CYCLES = 870
)
(
    input  wire        clock_in,     // system clock
    input  wire        rst_b_in,     // synchronous reset, active low
    input  wire        enable_in,    // look for a break while high
    input  wire        rx_in,        // uart receive line, idle high
    output reg         break_out     // sticky: break seen
);
    reg [23:0] low_count;

    // count consecutive low samples; any high sample restarts the count
    always @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            low_count <= 24'h000000;
            break_out <= 1'b0;
        end
        else if (!enable_in)
        begin
            low_count <= 24'h000000;
            break_out <= 1'b0;
        end
        else if (rx_in)
            low_count <= 24'h000000;
        else if (low_count == BREAK_CYCLES[23:0] - 24'h000001)
            break_out <= 1'b1;
        else
            low_count <= low_count + 24'h000001;
    end
endmodule
`default_nettype wire

//--- logic/bsm_boot_mode_select.v
// boot mode select: strap latch, boot flow and default pin mapping
// Overview of operation
// [RULE1] straps latched into a mode register at reset exit; it picks the mode
// [RULE2] latched code sets boot flow, debug port form and first uart mapping
// [RULE3] straps have internal pulldowns, so undriven lines read as zero
// [RULE4] board drives highest strap only as an output after power-up
// [RULE5] strap lines zero and one never offered to other pin functions
// [RULE6] code 100: serial code load, wait forever, four-wire debug
// [RULE7] after a load, board sets a functional code and resets again
// [RULE8] code 001: run with two-wire serial debug on tms and tck
// [RULE9] code 000: run with four-wire debug, the undriven default
// [RULE10] code 010: look for uart break; load if seen else run, four-wire
// [RULE11] code 011: reset toggle starts factory image restore
// [RULE12] restore is fail-safe, resumes after power loss, about eight seconds
// [RULE13] board holds reset low at least five milliseconds
// [RULE14] codes 101, 110, 111 act as the four-wire run default
`timescale 1ns/1ns
`default_nettype none
`include "bsm_map.vh"
module bsm_boot_mode_select
#(
    parameter integer BREAK_CYCLES   = `BSM_BREAK_CYCLES,
    parameter integer BREAK_WAIT     = `BSM_BREAK_WAIT_CYCLES,
    parameter [39:0]  RESTORE_CYCLES = `BSM_RESTORE_CYCLES
)
(
    input  wire        clock_in,            // 10 mhz system clock
    input  wire        rst_b_in,            // synchronous reset, active low
    input  wire [2:0]  boot_strap_lines_in, // strap pins, board side
    input  wire [2:0]  strap_pull_en_in,    // pad reports line is undriven
    input  wire        uart_rx_in,          // first uart receive line
    input  wire        load_done_in,        // loader finished a code load
    input  wire        restore_done_in,     // restore engine reports finish
    input  wire        restore_pending_in,  // nonvolatile restore-in-progress
    input  wire        strap_line_high_out_data_in, // reuse data for line 2
    output reg  [2:0]  strap_code_out,      // latched strap code
    output reg  [2:0]  boot_mode_out,       // selected boot flow
    output reg         debug_two_wire_out,  // 1 two-wire, 0 four-wire debug
    output reg         uart_loader_out,     // first uart owned by loader
    output reg         run_out,             // functional mode running
    output reg         restore_start_out,   // one-cycle restore kick
    output reg         restore_busy_out,    // restore in progress
    output reg         restore_mark_out,    // set nonvolatile restore marker
    output reg         strap_line_high_oe_out, // line 2 output enable
    output reg         strap_line_high_do_out, // line 2 output value
    output reg         strap_low_lines_free_out // always 0: lines 0,1 held
);
    // boot flow state
    localparam [2:0] ST_SENSE   = 3'h0;
    localparam [2:0] ST_RUN     = 3'h1;
    localparam [2:0] ST_LOAD    = 3'h2;
    localparam [2:0] ST_BREAK   = 3'h3;
    localparam [2:0] ST_RESTORE = 3'h4;

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [2:0]  next_mode;
    reg  [23:0] wait_count;
    reg  [39:0] restore_count;
    wire        break_seen;
    wire [2:0]  sensed;

    // pulled-down lines read zero when the pad reports nothing drives them
    assign sensed = boot_strap_lines_in & ~strap_pull_en_in; // RULE3

    // strap code to boot flow; undocumented codes fall back to four-wire run
    function [2:0] bsm_decode;
        input [2:0] code;
        begin
            case (code)
                `BSM_STRAP_LOAD:
                    bsm_decode = `BSM_MODE_LOAD;        // RULE6
                `BSM_STRAP_TWO_WIRE:
                    bsm_decode = `BSM_MODE_RUN_TWO;     // RULE8
                `BSM_STRAP_FOUR_WIRE:
                    bsm_decode = `BSM_MODE_RUN_FOUR;    // RULE9
                `BSM_STRAP_BREAK_LOAD:
                    bsm_decode = `BSM_MODE_BREAK_CHECK; // RULE10
                `BSM_STRAP_RESTORE:
                    bsm_decode = `BSM_MODE_RESTORE;     // RULE11
                default:
                    bsm_decode = `BSM_MODE_RUN_FOUR;    // RULE14
            endcase
        end
    endfunction

    bsm_break_detect
    #(
        .BREAK_CYCLES (BREAK_CYCLES)
    )
    u_break
    (
        .clock_in  (clock_in),
        .rst_b_in  (rst_b_in),
        .enable_in (state == ST_BREAK),
        .rx_in     (uart_rx_in),
        .break_out (break_seen)
    );

    // next flow state; a pending restore marker wins so power loss resumes it
    always @*
    begin
        next_state = state;
        next_mode  = boot_mode_out;
        case (state)
            ST_SENSE:
            begin
                if (restore_pending_in)
                    next_mode = `BSM_MODE_RESTORE;           // RULE12
                else
                    // decide from the pins: the latch still holds its reset
                    // value on this edge and takes the same code with it
                    next_mode = bsm_decode(sensed);          // RULE1
                case (next_mode)
                    `BSM_MODE_LOAD:        next_state = ST_LOAD;
                    `BSM_MODE_BREAK_CHECK: next_state = ST_BREAK;
                    `BSM_MODE_RESTORE:     next_state = ST_RESTORE;
                    default:               next_state = ST_RUN;
                endcase
            end
            ST_LOAD:
                // no timeout: only a new strap code and reset leave here
                next_state = ST_LOAD;                        // RULE6
            ST_BREAK:
            begin
                if (break_seen)
                begin
                    next_state = ST_LOAD;                    // RULE10
                    next_mode  = `BSM_MODE_LOAD;
                end
                else if (wait_count == BREAK_WAIT[23:0])
                begin
                    next_state = ST_RUN;                     // RULE10
                    next_mode  = `BSM_MODE_RUN_FOUR;
                end
            end
            ST_RESTORE:
            begin
                if (restore_done_in || restore_count == RESTORE_CYCLES)
                begin
                    next_state = ST_RUN;
                    next_mode  = `BSM_MODE_RUN_FOUR;
                end
            end
            ST_RUN:
                next_state = ST_RUN;
            default:
                next_state = ST_SENSE;
        endcase
    end

    // strap latch and flow registers; the latch takes the pins on the first
    // edge after release, since async capture of a pin is not allowed
    always @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            state          <= ST_SENSE;
            strap_code_out <= `BSM_RST_STRAP;
            boot_mode_out  <= `BSM_RST_MODE;
            wait_count     <= 24'h000000;
            restore_count  <= 40'h0000000000;
        end
        else
        begin
            if (state == ST_SENSE)
                strap_code_out <= sensed;                    // RULE1
            state         <= next_state;
            boot_mode_out <= next_mode;                      // RULE2
            if (state == ST_BREAK)
                wait_count <= wait_count + 24'h000001;
            else
                wait_count <= 24'h000000;
            if (state == ST_RESTORE)
                restore_count <= restore_count + 40'h0000000001;
            else
                restore_count <= 40'h0000000000;
        end
    end

    // pin mapping and status outputs, all registered
    always @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            debug_two_wire_out       <= `BSM_DBG_FOUR_WIRE;
            uart_loader_out          <= 1'b0;
            run_out                  <= 1'b0;
            restore_start_out        <= 1'b0;
            restore_busy_out         <= 1'b0;
            restore_mark_out         <= 1'b0;
            strap_line_high_oe_out   <= 1'b0;
            strap_line_high_do_out   <= 1'b0;
            strap_low_lines_free_out <= 1'b0;
        end
        else
        begin
            debug_two_wire_out <= (next_mode == `BSM_MODE_RUN_TWO)
                ? `BSM_DBG_TWO_WIRE : `BSM_DBG_FOUR_WIRE;    // RULE2
            uart_loader_out    <= (next_state == ST_LOAD) ||
                                  (next_state == ST_BREAK);  // RULE2
            run_out            <= (next_state == ST_RUN);
            restore_start_out  <= (state == ST_SENSE) &&
                                  (next_state == ST_RESTORE); // RULE11
            restore_busy_out   <= (next_state == ST_RESTORE);
            // marker set while the restore runs and load_done_in is low, covering power loss
            restore_mark_out   <= (next_state == ST_RESTORE) &&
                                  !load_done_in;             // RULE12
            // line 2 may be reused only as an output once running
            strap_line_high_oe_out <= (next_state == ST_RUN);
            strap_line_high_do_out <= (next_state == ST_RUN) &&
                                      strap_line_high_out_data_in;
            strap_low_lines_free_out <= 1'b0;                // RULE5
        end
    end
endmodule
`default_nettype wire

//--- tb/bsm_strap_board.sv
// board side model: strap drive, pad pulldowns and line 2 reuse
`timescale 1ns/1ns
`default_nettype none
module bsm_strap_board
(
    input  wire logic [2:0] code_in,     // levels the board straps to
    input  wire logic [2:0] drive_in,    // high where the board drives
    input  wire logic       oe_in,       // device drives line 2
    input  wire logic       do_in,       // device value on line 2
    output logic      [2:0] lines_out,   // level seen at the pads
    output logic      [2:0] pull_en_out  // lines left undriven
);
    // undriven lines settle low; the board never fights line 2 once reused
    always_comb
    begin
        lines_out = code_in & drive_in;
        pull_en_out = ~drive_in;
        lines_out[2] = oe_in ? do_in : lines_out[2];
        pull_en_out[2] = pull_en_out[2] & ~oe_in;
    end
endmodule
`default_nettype wire

//--- tb/bsm_boot_mode_select_sva.sv
// assertions on the boot mode select ports
`timescale 1ns/1ns
`default_nettype none
module bsm_sva
#(
    parameter integer BREAK_CYCLES = 4,
    parameter integer BREAK_WAIT   = 20
)
(
    input wire logic       clock_in,                // system clock
    input wire logic       rst_b_in,                // reset, active low
    input wire logic       uart_rx_in,              // receive line
    input wire logic       restore_pending_in,      // restore marker
    input wire logic [2:0] strap_code_out,          // latched code
    input wire logic [2:0] boot_mode_out,           // boot flow
    input wire logic       debug_two_wire_out,      // debug form
    input wire logic       uart_loader_out,         // uart to loader
    input wire logic       restore_start_out,       // restore kick
    input wire logic       restore_busy_out,        // restore running
    input wire logic       strap_low_lines_free_out // lines 0,1 offered
);
    logic [15:0] low_cnt, chk_cnt;
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);
    // counts bound the break check, which must never hang
    always_ff @(posedge clock_in)
    begin
        chk_cnt <= (!rst_b_in || boot_mode_out != 3'h3) ? 16'h0
                   : chk_cnt + 16'h1;
        low_cnt <= (!rst_b_in || boot_mode_out != 3'h3 || uart_rx_in)
                   ? 16'h0 : low_cnt + 16'h1;
    end
    reset_clear_a: assert property (
        $rose(rst_b_in) |-> boot_mode_out == 3'h0 && !restore_busy_out)
        else $error("outputs not cleared by reset");
    code_hold_a: assert property (
        $past(rst_b_in) && $past(rst_b_in, 2) |-> $stable(strap_code_out))
        else $error("latched code moved");
    load_mode_a: assert property (
        strap_code_out == 3'h4 && !restore_pending_in
        |-> ##[0:2] boot_mode_out == 3'h2)
        else $error("load code did not load");
    load_form_a: assert property (
        boot_mode_out == 3'h2 |-> ##1 uart_loader_out && !debug_two_wire_out)
        else $error("load without uart or four-wire");
    two_wire_a: assert property (
        debug_two_wire_out |-> strap_code_out == 3'h1)
        else $error("two-wire debug on wrong code");
    low_free_a: assert property (
        !strap_low_lines_free_out)
        else $error("low strap lines offered");
    start_pulse_a: assert property (
        restore_start_out |=> !restore_start_out && restore_busy_out)
        else $error("restore kick not a pulse");
    break_len_a: assert property (
        boot_mode_out == 3'h3 |-> low_cnt <= BREAK_CYCLES + 2)
        else $error("break not taken");
    wait_len_a: assert property (
        boot_mode_out == 3'h3 |-> chk_cnt <= BREAK_WAIT + 3)
        else $error("break check never ended");
endmodule
bind bsm_boot_mode_select bsm_sva #(.BREAK_CYCLES(BREAK_CYCLES),
    .BREAK_WAIT(BREAK_WAIT)) sva (.clock_in, .rst_b_in, .uart_rx_in,
    .restore_pending_in, .strap_code_out, .boot_mode_out, .debug_two_wire_out,
    .uart_loader_out, .restore_start_out, .restore_busy_out,
    .strap_low_lines_free_out);
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for boot mode select
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic       clock_in = 1'b0, rst_b_in = 1'b0;
    logic       rx = 1'b1, done = 1'b0, pend = 1'b0, reuse = 1'b0;
    logic [2:0] code = 3'h0, drive = 3'h7, lines, pull, scode, mode;
    logic       two, ldr, run, start, busy, mark, oe, dout, free;
    integer     error_cnt = 0, comparisons = 0, cycles = 0;
    bsm_boot_mode_select #(.BREAK_CYCLES(4), .BREAK_WAIT(20),
        .RESTORE_CYCLES(40'd50)) uut (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .boot_strap_lines_in(lines), .strap_pull_en_in(pull), .uart_rx_in(rx),
        .load_done_in(1'b0), .restore_done_in(done), .restore_pending_in(pend),
        .strap_line_high_out_data_in(reuse), .strap_code_out(scode),
        .boot_mode_out(mode), .debug_two_wire_out(two), .uart_loader_out(ldr),
        .run_out(run), .restore_start_out(start), .restore_busy_out(busy),
        .restore_mark_out(mark), .strap_line_high_oe_out(oe),
        .strap_line_high_do_out(dout), .strap_low_lines_free_out(free));
    bsm_strap_board board (.code_in(code), .drive_in(drive), .oe_in(oe),
        .do_in(dout), .lines_out(lines), .pull_en_out(pull));
    always #50 clock_in = ~clock_in;
    // a hang is cut short well past the longest sequence
    always @(posedge clock_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            error_cnt++;
            test_done;
        end
    end
    task chk(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp)
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        if (got !== exp)
            error_cnt++;
    endtask
    task test_done;
        if (error_cnt == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // straps and inputs settle during reset; look once the choice has landed
    task boot(input logic [2:0] c, input logic [2:0] d, input logic r, p);
        @(posedge clock_in);
        {rst_b_in, code, drive, rx, done, pend} <= {1'b0, c, d, r, 1'b0, p};
        // rst_b_in is the filtered reset, so the long pin hold is shortened
        repeat (8) @(posedge clock_in);
        rst_b_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        #1;
    endtask
    // listed and unlisted codes; back-to-back boots also cover reloading
    task t_codes;
        for (int i = 0; i < 8; i++)
            if (i != 2 && i != 3)
            begin
                boot(i[2:0], 3'h7, 1'b1, 1'b0);
                chk(scode, i[2:0]);
                chk(mode, {i == 4, i == 1});
                chk({two, ldr, free}, {i == 1, i == 4, 1'b0});
            end
    endtask
    // undriven straps, then late strap changes and line 2 reuse
    task t_hold;
        boot(3'h7, 3'h0, 1'b1, 1'b0);
        chk(scode, 3'h0);
        @(posedge clock_in);
        {code, drive, reuse} <= {3'h4, 3'h3, 1'b1};
        repeat (3) @(posedge clock_in);
        #1;
        chk({scode, run}, 4'h1);
        chk({oe, dout, lines[2]}, 3'h7);
    endtask
    // break present, then absent until the wait runs out
    task t_break;
        boot(3'h2, 3'h7, 1'b0, 1'b0);
        repeat (8) @(posedge clock_in);
        #1;
        chk({ldr, mode}, 4'ha);
        boot(3'h2, 3'h7, 1'b1, 1'b0);
        chk({two, mode}, 4'h3);
        repeat (25) @(posedge clock_in);
        #1;
        chk({run, mode}, 4'h8);
    endtask
    // restore from straps, its end, then a restore left pending
    task t_restore;
        boot(3'h3, 3'h7, 1'b1, 1'b0);
        chk({busy, mode}, 4'hc);
        chk(mark, 1'b1);
        @(posedge clock_in);
        done <= 1'b1;
        repeat (3) @(posedge clock_in);
        #1;
        chk(busy, 1'b0);
        chk(mark, 1'b0);
        boot(3'h0, 3'h7, 1'b1, 1'b1);
        chk(busy, 1'b1);
        // with no finish report the restore runs until its cycle limit
        repeat (46) @(posedge clock_in);
        #1;
        chk(busy, 1'b1);
        repeat (4) @(posedge clock_in);
        #1;
        chk({busy, run}, 4'h1);
    endtask
    initial
    begin
        t_codes;
        t_hold;
        t_break;
        t_restore;
        test_done;
    end
endmodule
`default_nettype wire
